/* File: pkg/rev_limit_pkg.sv */
// rev limiter package: register map, field layouts, mode encodings
// assumes a 32-bit apb bus with word-aligned registers
package rev_limit_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_HARD_LIMIT = 8'h00;
    localparam logic [7:0] ADDR_SOFT_ZONE = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_BYPASS = 8'h0C;
    localparam logic [7:0] ADDR_RETARD = 8'h10;
    localparam logic [7:0] ADDR_CURVE_SEL = 8'h14;
    localparam logic [7:0] ADDR_CURVE_DATA = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_LIMIT_NOW = 8'h20;
    // control register bit positions
    localparam int CTL_COOLANT_MODE = 0;
    localparam int CTL_FUEL_EN = 1;
    localparam int CTL_FUEL_PROG = 2;
    localparam int CTL_SPARK_CUT = 3;
    localparam int CTL_RETARD_LO = 4;
    localparam int CTL_DIRECT_SPARK = 6;
    localparam int CTL_PORT_INJ = 7;
    // reset values
    localparam logic [15:0] HARD_LIMIT_RST = 16'h1B58;
    localparam logic [15:0] SOFT_ZONE_RST = 16'h00C8;
    localparam logic [7:0] BYPASS_RST = 8'h5F;
    localparam logic [7:0] ANGLE_RST = 8'h00;
    localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;

    typedef enum logic [1:0] {
        RETARD_OFF,
        RETARD_PROGRESSIVE,
        RETARD_FIXED
    } retard_mode_t;

    // sensor sample carried together into the limiter
    typedef struct packed {
        logic [15:0] engine_speed;
        logic [7:0] coolant_temperature;
        logic [7:0] throttle_position;
    } sensor_t;

    // ignition decision for one event
    typedef struct packed {
        logic [7:0] angle;
        logic angle_override;
        logic spark_kill;
    } spark_out_t;
endpackage : rev_limit_pkg

/* File: core/engine_rev_limiter.sv */
// engine speed limiter: retard, spark cut and fuel cut behind an apb slave
// assumes sensors are filtered and synchronous, one event strobe per firing
//
// How it works
// (R01) at hard limit apply fuel cut or full spark cut per method
// (R02) hard fuel cut holds until speed falls below hard minus soft zone
// (R03) soft limit is hard minus soft zone; retard starts there
// (R04) coolant mode takes hard limit from coolant-indexed curve
// (R05) throttle above bypass percent forces the fixed hard limit
// (R06) retard setting is the absolute total ignition angle
// (R07) retard mode off means no retard limiting at all
// (R08) progressive retard grows with speed, full at hard limit
// (R09) fixed mode jumps to limiter angle at the soft limit
// (R10) retard never exceeds the configured maximum retard
// (R11) spark cut only when the device owns every ignition event
// (R12) spark cuts rotate round-robin among cylinders
// (R13) spark cut fraction rises from soft limit to all at hard limit
// (R14) fuel cut enable gates the whole fuel limiter
// (R15) abrupt fuel cut removes all cylinders at the hard limit
// (R16) progressive fuel cut: one cylinder at soft, all at hard
// (R17) progressive cut cylinders stay cut until speed restores them
// (R18) progressive fuel cut only with one injector per cylinder
// (R19) thresholds and patterns re-evaluated once per engine event
//
// Registers (byte offsets)
// 00 hard limit, 04 soft zone, 08 control, 0C throttle bypass percent
// 10 limiter angle low byte, maximum retard next byte
// 14 curve point index, 18 curve point {temperature, limit}
// 1C status (read only), 20 active limit (read only)
// control: 0 coolant mode, 1 fuel cut, 2 progressive fuel, 3 spark cut
// control: 5:4 retard mode, 6 device owns spark, 7 one injector per cyl
//
// Timing
// bus: setup, access, then one cycle with pready; writes land on that edge
// limiter: an event edge updates the spark word and the cut state
// gates follow one clock later and then stand until the next event
// a limit change (register or coolant curve) takes hold one event late,
// so a fresh threshold never splits the decisions of a single event
// control writes between events never move a gate on their own
//
// Limitations
// the coolant curve is searched, not interpolated, so keep it monotonic
// spark cut pacing assumes events evenly spread over the cylinders
// the soft zone is clipped to the active limit to keep thresholds sane
`timescale 1ns/1ps
`default_nettype none
module engine_rev_limiter
    import rev_limit_pkg::*;
#(
    parameter int CYLINDERS = 8,
    parameter int CURVE_POINTS = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sensor_t sensors,
    input wire logic engine_event,
    input wire logic [7:0] base_angle,
    output spark_out_t spark,
    output logic [CYLINDERS-1:0] fuel_enable,
    output logic [CYLINDERS-1:0] spark_enable
);
    localparam int CW = $clog2(CYLINDERS);
    localparam int PW = $clog2(CURVE_POINTS);

    // configuration registers
    logic [15:0] hard_limit;
    logic [15:0] soft_zone;
    logic [7:0] control;
    logic [7:0] bypass_pct;
    logic [7:0] retard_angle;
    logic [7:0] max_retard;
    logic [PW-1:0] curve_sel;
    logic [15:0] curve_limit [CURVE_POINTS];
    logic [7:0] curve_temp [CURVE_POINTS];

    // limiter state
    logic [15:0] limit_now;
    logic fuel_latched;
    logic [CW-1:0] rr_index;
    logic [CW:0] cut_count;
    logic [7:0] cut_acc;
    // spark cut decision held from one event to the next
    logic spark_cut_now;
    logic [CW-1:0] cut_slot;

    // apb decode
    // a write lands only on the edge where pready is sampled high
    wire wr_en = psel && penable && pwrite && pready;
    wire rd_en = psel && penable && !pwrite;
    wire hit_hard = paddr == ADDR_HARD_LIMIT;
    wire hit_zone = paddr == ADDR_SOFT_ZONE;
    wire hit_ctl = paddr == ADDR_CONTROL;
    wire hit_byp = paddr == ADDR_BYPASS;
    wire hit_ret = paddr == ADDR_RETARD;
    wire hit_sel = paddr == ADDR_CURVE_SEL;
    wire hit_crv = paddr == ADDR_CURVE_DATA;
    wire hit_sts = paddr == ADDR_STATUS;
    wire hit_lim = paddr == ADDR_LIMIT_NOW;
    wire hit_any = hit_hard || hit_zone || hit_ctl || hit_byp || hit_ret
        || hit_sel || hit_crv || hit_sts || hit_lim;

    // control fields
    // the refusals below are applied here so every user sees the same gate
    wire coolant_mode = control[CTL_COOLANT_MODE];
    wire fuel_en = control[CTL_FUEL_EN];
    wire direct_spark = control[CTL_DIRECT_SPARK];
    wire port_inj = control[CTL_PORT_INJ];
    // progressive cut refused unless one injector per cylinder
    wire fuel_prog = control[CTL_FUEL_PROG] && port_inj; // R18
    // spark cut is pointless when an outside module times the spark
    wire spark_cut_en = control[CTL_SPARK_CUT] && direct_spark; // R11
    wire [1:0] mode_bits = control[CTL_RETARD_LO +: 2];

    // curve lookup: first point whose temperature is at or above coolant
    // unused points reset to the top temperature, so the search always
    // ends on a programmed or default limit
    logic [15:0] curve_pick;
    always_comb begin
        curve_pick = curve_limit[CURVE_POINTS-1];
        for (int i = CURVE_POINTS - 1; i >= 0; i--) begin
            if (sensors.coolant_temperature <= curve_temp[i]) begin
                curve_pick = curve_limit[i];
            end
        end
    end

    // limit selection
    // the active limit is registered at each event; comparisons use it so
    // that the soft and hard thresholds of one event always belong together
    wire bypass = sensors.throttle_position > bypass_pct; // R05
    wire use_curve = coolant_mode && !bypass; // R04
    wire [15:0] next_limit = use_curve ? curve_pick : hard_limit;
    wire [15:0] zone_eff = (soft_zone > limit_now) ? limit_now : soft_zone;
    wire [15:0] soft_limit = limit_now - zone_eff; // R03
    wire [15:0] rpm = sensors.engine_speed;
    wire at_hard = rpm >= limit_now;
    wire at_soft = rpm >= soft_limit;
    wire [15:0] over = at_soft ? rpm - soft_limit : 16'h0000;
    // fraction of the soft zone covered, 0..255
    // a zero zone means the whole ramp collapses onto the hard limit
    wire [23:0] frac_full = (zone_eff == 16'h0000) ? 24'h0000FF :
        ({over, 8'h00} / {8'h00, zone_eff});
    wire [7:0] frac = (at_hard || frac_full > 24'h0000FF) ? 8'hFF :
        frac_full[7:0];

    // retard angle: setting is the total angle, floor held by max retard
    // full drop from base timing down to the limiter angle
    wire [7:0] fixed_drop = (base_angle > retard_angle) ?
        base_angle - retard_angle : 8'h00;
    // scaled part of that drop; the top of the ramp takes all of it, so
    // the limiter angle is really reached at the hard limit
    wire [15:0] drop_scaled = ({8'h00, fixed_drop} * {8'h00, frac}) >> 8;
    wire [7:0] prog_drop = (frac == 8'hFF) ? fixed_drop : drop_scaled[7:0];
    wire [7:0] drop_cap = (prog_drop > max_retard) ? max_retard :
        prog_drop; // R10
    wire [7:0] fixed_cap = (fixed_drop > max_retard) ? max_retard :
        fixed_drop; // R10
    logic [7:0] next_angle;
    logic next_override;
    always_comb begin
        next_angle = base_angle;
        next_override = 1'b0;
        case (retard_mode_t'(mode_bits))
            RETARD_OFF: begin
                next_override = 1'b0; // R07
            end
            RETARD_PROGRESSIVE: begin
                next_override = at_soft; // R08
                next_angle = base_angle - drop_cap; // R06
            end
            RETARD_FIXED: begin
                next_override = at_soft; // R09
                next_angle = base_angle - fixed_cap; // R06
            end
            default: begin
                next_override = 1'b0;
            end
        endcase
    end

    // progressive fuel target: one cylinder at soft, all at hard
    wire [CW+8:0] span = (CW+9)'((CYLINDERS - 1) * frac);
    wire [CW:0] prog_target = at_hard ? (CW+1)'(CYLINDERS) :
        at_soft ? (CW+1)'(1 + span / 255) : '0; // R16
    // cut cylinders only come back together, once speed is below soft
    // limit, so a cylinder never toggles inside the zone
    wire fuel_release = rpm < soft_limit; // R02
    wire [CW:0] next_cut = !fuel_en ? '0 : // R14
        (prog_target > cut_count) ? prog_target :
        (fuel_release ? '0 : cut_count); // R17

    // spark cut pacing: accumulate fraction, cut when it wraps
    // an accumulator spreads the cuts evenly instead of bunching them,
    // at the cost of a pattern that depends on the speed history
    wire [8:0] acc_sum = {1'b0, cut_acc} + {1'b0, frac};
    wire cut_this = spark_cut_en && at_soft && (at_hard || acc_sum[8]);

    // apb register writes
    // unmapped offsets fall through every hit and change nothing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hard_limit <= HARD_LIMIT_RST;
            soft_zone <= SOFT_ZONE_RST;
            control <= 8'h00;
            bypass_pct <= BYPASS_RST;
            retard_angle <= ANGLE_RST;
            max_retard <= ANGLE_RST;
            curve_sel <= '0;
        end else if (wr_en) begin
            if (hit_hard) hard_limit <= pwdata[15:0];
            if (hit_zone) soft_zone <= pwdata[15:0];
            if (hit_ctl) control <= pwdata[7:0];
            if (hit_byp) bypass_pct <= pwdata[7:0];
            if (hit_ret) begin
                retard_angle <= pwdata[7:0];
                max_retard <= pwdata[15:8];
            end
            if (hit_sel) curve_sel <= pwdata[PW-1:0];
        end
    end

    // curve storage, reset to the fixed default limit
    // the index register picks the point, so one word reaches any point
    always_ff @(posedge clk) begin
        for (int i = 0; i < CURVE_POINTS; i++) begin
            if (!resetn) begin
                curve_limit[i] <= HARD_LIMIT_RST;
                curve_temp[i] <= 8'hFF;
            end else if (wr_en && hit_crv && curve_sel == PW'(i)) begin
                curve_limit[i] <= pwdata[15:0];
                curve_temp[i] <= pwdata[23:16];
            end
        end
    end

    // status word: cut count, latched fuel cut, spark kill and override
    wire [31:0] status_word = {20'h00000, 4'(cut_count), 5'h00,
        fuel_latched, spark.spark_kill, spark.angle_override};

    // the first access cycle with no answer out yet raises pready, which
    // then drops, giving exactly one wait state per transfer
    wire answer_now = psel && penable && !pready;

    // apb read and answer, one wait state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= answer_now;
            pslverr <= answer_now && !hit_any;
            prdata <= PSLVERR_NONE;
            if (answer_now && !pwrite) begin
                if (hit_hard) prdata <= {16'h0000, hard_limit};
                if (hit_zone) prdata <= {16'h0000, soft_zone};
                if (hit_ctl) prdata <= {24'h000000, control};
                if (hit_byp) prdata <= {24'h000000, bypass_pct};
                if (hit_ret) prdata <= {16'h0000, max_retard, retard_angle};
                if (hit_sel) prdata <= 32'(curve_sel);
                if (hit_crv) prdata <= {8'h00, curve_temp[curve_sel],
                    curve_limit[curve_sel]};
                if (hit_sts) prdata <= status_word;
                if (hit_lim) prdata <= {16'h0000, limit_now};
            end
        end
    end

    // per-event limiter update
    // nothing here moves between events, so outputs stay steady while
    // the sensors wander between firings
    always_ff @(posedge clk) begin
        if (!resetn) begin
            limit_now <= HARD_LIMIT_RST;
            fuel_latched <= 1'b0;
            rr_index <= '0;
            cut_count <= '0;
            cut_acc <= 8'h00;
            spark <= '0;
            spark_cut_now <= 1'b0;
            cut_slot <= '0;
        end else if (engine_event) begin // R19
            limit_now <= next_limit;
            // abrupt cut: set at hard limit, clear past hysteresis
            if (!fuel_en || fuel_prog) begin
                fuel_latched <= 1'b0; // R14
            end else if (at_hard) begin
                fuel_latched <= 1'b1; // R15
            end else if (fuel_release) begin
                fuel_latched <= 1'b0; // R02
            end
            cut_count <= fuel_prog ? next_cut : '0;
            cut_acc <= at_soft ? acc_sum[7:0] : 8'h00;
            if (cut_this) begin
                rr_index <= (rr_index == CW'(CYLINDERS - 1)) ? '0 :
                    rr_index + 1'b1; // R12
            end
            spark.angle <= next_angle;
            spark.angle_override <= next_override;
            spark.spark_kill <= spark_cut_en && at_hard; // R01
            // remember which cylinder loses its spark until the next event
            spark_cut_now <= cut_this;
            cut_slot <= rr_index; // R12
        end
    end

    // per-cylinder gates, built only from state that changes at events, so
    // they stand until the next one; fuel cuts fill from cylinder 0 upward
    genvar g;
    generate
        for (g = 0; g < CYLINDERS; g++) begin : g_cyl
            // cut_count is zero unless the progressive cut is armed
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    fuel_enable[g] <= 1'b1;
                end else begin
                    fuel_enable[g] <= !(fuel_latched ||
                        cut_count > (CW+1)'(g)); // R01
                end
            end
            // one rotating cylinder, or all of them at the hard limit
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    spark_enable[g] <= 1'b1;
                end else begin
                    spark_enable[g] <= !(spark.spark_kill ||
                        (spark_cut_now && cut_slot == CW'(g))); // R13
                end
            end
        end
    endgenerate
endmodule // engine_rev_limiter
`default_nettype wire

/* File: bench/engine_side_model.sv */
// engine side model: filtered sensor samples and one event per firing
// assumes the bench calls fire() and clk is the limiter clock
`timescale 1ns/1ps
`default_nettype none
module engine_side_model
    import rev_limit_pkg::*;
(
    input wire logic clk,
    output var sensor_t sensors,
    output logic engine_event,
    output logic [7:0] base_angle
);
    // base timing sits above every limiter angle so an override shows
    initial begin
        sensors = '0;
        engine_event = 1'b0;
        base_angle = 8'h1E;
    end
    // sample changes with a single-cycle event, as a real trigger would
    task automatic fire(input logic [15:0] s, input logic [7:0] t, p);
        @(posedge clk);
        sensors <= '{engine_speed: s, coolant_temperature: t,
                     throttle_position: p};
        engine_event <= 1'b1;
        @(posedge clk);
        engine_event <= 1'b0;
    endtask
endmodule // engine_side_model
`default_nettype wire

/* File: bench/engine_rev_limiter_assertions.sv */
// checker: apb timing and event-paced limiter outputs at the top ports
// assumes synchronous active-low reset and a sane soft zone
`timescale 1ns/1ps
`default_nettype none
module engine_rev_limiter_assertions
    import rev_limit_pkg::*;
#(
    parameter int CYLINDERS = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire sensor_t sensors,
    input wire logic engine_event,
    input wire spark_out_t spark,
    input wire logic [CYLINDERS-1:0] fuel_enable,
    input wire logic [CYLINDERS-1:0] spark_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // bus answer: one wait state, then a single-cycle pready
    AST_APB_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not two cycles after setup");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    // outputs only move after an event, never from bus traffic alone
    AST_SPARK_AT_EVENT: assert property ($changed(spark) |->
        $past(engine_event)) else $error("spark moved without event");
    AST_GATES_AT_EVENT: assert property ($changed({fuel_enable,
        spark_enable}) |-> $past(engine_event, 2))
        else $error("gates moved without event");
    // fuel comes back to every cylinder together
    AST_FUEL_RESTORE: assert property ((|(fuel_enable &
        ~$past(fuel_enable))) |-> &fuel_enable)
        else $error("partial fuel restore");
    // a stopped engine is below every limit
    AST_IDLE_FUEL: assert property (engine_event &&
        sensors.engine_speed == 16'h0000 |-> ##2 &fuel_enable)
        else $error("fuel cut at zero speed");
    AST_IDLE_SPARK: assert property (engine_event &&
        sensors.engine_speed == 16'h0000 |-> ##2 &spark_enable)
        else $error("spark cut at zero speed");
    AST_IDLE_ANGLE: assert property (engine_event &&
        sensors.engine_speed == 16'h0000 |=> !spark.angle_override)
        else $error("retard at zero speed");
    COV_FUEL_CUT: cover property (fuel_enable == '0);
    COV_SPARK_CUT: cover property (spark_enable == '0);
    COV_OVERRIDE: cover property (spark.angle_override);
endmodule // engine_rev_limiter_assertions
bind engine_rev_limiter engine_rev_limiter_assertions #(
    .CYLINDERS(CYLINDERS)
) u_engine_rev_limiter_assertions (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .sensors(sensors), .engine_event(engine_event),
    .spark(spark), .fuel_enable(fuel_enable), .spark_enable(spark_enable)
);
`default_nettype wire

/* File: bench/engine_rev_limiter_tb.sv */
// testbench: fuel, spark and coolant limiter scenarios over apb
// assumes the side model owns sensors, events and base timing
`timescale 1ns/1ps
`default_nettype none
module engine_rev_limiter_tb;
    import rev_limit_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic pready, pslverr, engine_event, re;
    logic [7:0] base_angle, fuel_enable, spark_enable;
    sensor_t sensors;
    spark_out_t spark;
    int err_total = 0;
    int n_tests = 0;
    engine_rev_limiter #(.CYLINDERS(8), .CURVE_POINTS(8)) u_engine_rev_limiter (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sensors(sensors),
        .engine_event(engine_event), .base_angle(base_angle), .spark(spark),
        .fuel_enable(fuel_enable), .spark_enable(spark_enable));
    engine_side_model u_engine_side_model (.clk(clk), .sensors(sensors),
        .engine_event(engine_event), .base_angle(base_angle));
    initial forever #10 clk = ~clk;
    task automatic chk(input string w, input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    // request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // gates settle one cycle after the event edge
    task automatic ev(input logic [15:0] s, input logic [7:0] t, p);
        u_engine_side_model.fire(s, t, p);
        repeat (3) @(posedge clk);
    endtask
    // a zero-speed event flushes latched cuts and the pending limit
    task automatic cfg(input logic [31:0] c);
        apb(1'b1, ADDR_CONTROL, c);
        ev(16'h0000, 8'h00, 8'h00);
    endtask
    task automatic test_fuel;
        cfg(32'h0000_0002);
        ev(16'h1B58, 8'h00, 8'h00);
        chk("abrupt cut", 32'(fuel_enable), 32'h0);
        ev(16'h1B00, 8'h00, 8'h00);
        chk("hysteresis hold", 32'(fuel_enable), 32'h0);
        ev(16'h1A8F, 8'h00, 8'h00);
        chk("hysteresis end", 32'(fuel_enable), 32'hFF);
        cfg(32'h0000_0000);
        ev(16'h1B58, 8'h00, 8'h00);
        chk("fuel disabled", 32'(fuel_enable), 32'hFF);
        cfg(32'h0000_0086);
        ev(16'h1A90, 8'h00, 8'h00);
        chk("prog one", 32'($countones(fuel_enable)), 32'h7);
        ev(16'h1B58, 8'h00, 8'h00);
        chk("prog all", 32'(fuel_enable), 32'h0);
        ev(16'h1B00, 8'h00, 8'h00);
        chk("prog stays", 32'(fuel_enable), 32'h0);
        cfg(32'h0000_0006);
        ev(16'h1A90, 8'h00, 8'h00);
        chk("prog refused", 32'(fuel_enable), 32'hFF);
        $display("test fuel done");
    endtask
    task automatic test_spark;
        logic [7:0] acc;
        acc = 8'h00;
        cfg(32'h0000_0048);
        ev(16'h1B58, 8'h00, 8'h00);
        chk("spark all cut", 32'(spark_enable), 32'h0);
        repeat (8) begin
            ev(16'h1AF4, 8'h00, 8'h00);
            acc = acc | ~spark_enable;
        end
        chk("rotation", 32'($countones(acc) > 1), 32'h1);
        cfg(32'h0000_0008);
        ev(16'h1B58, 8'h00, 8'h00);
        chk("no direct spark", 32'(spark_enable), 32'hFF);
        apb(1'b1, ADDR_RETARD, 32'h0000_140A);
        cfg(32'h0000_0020);
        ev(16'h1A90, 8'h00, 8'h00);
        chk("fixed angle", 32'(spark.angle), 32'h0A);
        ev(16'h1A8F, 8'h00, 8'h00);
        chk("below soft", 32'(spark.angle_override), 32'h0);
        cfg(32'h0000_0010);
        ev(16'h1B58, 8'h00, 8'h00);
        chk("prog at hard", 32'(spark.angle), 32'h0A);
        cfg(32'h0000_0000);
        ev(16'h1B58, 8'h00, 8'h00);
        chk("retard off", 32'(spark.angle_override), 32'h0);
        $display("test spark done");
    endtask
    task automatic test_coolant;
        apb(1'b0, ADDR_HARD_LIMIT, 32'h0);
        chk("hard reset", rq, {16'h0000, HARD_LIMIT_RST});
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped data", rq, 32'h0);
        chk("unmapped err", 32'(re), 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_CURVE_SEL, 32'(i));
            apb(1'b1, ADDR_CURVE_DATA, 32'h00FF_0FA0);
        end
        cfg(32'h0000_0003);
        ev(16'h0FA0, 8'h20, 8'h00);
        chk("curve limit", 32'(fuel_enable), 32'h0);
        ev(16'h0000, 8'h20, 8'h60);
        ev(16'h0FA0, 8'h20, 8'h60);
        chk("throttle bypass", 32'(fuel_enable), 32'hFF);
        cfg(32'h0000_0002);
        ev(16'h0FA0, 8'h20, 8'h00);
        chk("normal mode", 32'(fuel_enable), 32'hFF);
        $display("test coolant done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        test_fuel;
        test_spark;
        test_coolant;
        test_done;
    end
endmodule // engine_rev_limiter_tb
`default_nettype wire
